// >>> pkg/afd_extract_pkg.sv
// constants, types and reset values for the active format extractor
// assumes a single pclk domain and word-indexed registers on apb
package afd_extract_pkg;

  // ----------------------------------------------------------------
  // stream layout
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W   = 10;
  localparam logic [3:0]  TYPE_ANC = 4'hD;
  localparam logic [3:0]  TYPE_IMG = 4'h0;

  // ----------------------------------------------------------------
  // ancillary packet matching and payload positions
  // ----------------------------------------------------------------
  localparam logic [7:0] AFD_DID       = 8'h41;
  localparam logic [7:0] AFD_SDID      = 8'h05;
  localparam logic [7:0] AFD_DC        = 8'h08;
  localparam logic [7:0] POS_DID       = 8'h00;
  localparam logic [7:0] POS_SDID      = 8'h01;
  localparam logic [7:0] POS_DC        = 8'h02;
  localparam logic [7:0] POS_CODE      = 8'h03;
  localparam logic [7:0] POS_FLAGS     = 8'h06;
  localparam logic [7:0] POS_BAR1_HI   = 8'h07;
  localparam logic [7:0] POS_BAR1_LO   = 8'h08;
  localparam logic [7:0] POS_BAR2_HI   = 8'h09;
  localparam logic [7:0] POS_BAR2_LO   = 8'h0A;
  localparam logic [7:0] POS_LAST_OFS  = 8'h02;

  // ----------------------------------------------------------------
  // register indices (byte address is index times four)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [5:0]  IDX_CTRL    = 6'h00;
  localparam logic [5:0]  IDX_RSVD    = 6'h01;
  localparam logic [5:0]  IDX_IRQ     = 6'h02;
  localparam logic [5:0]  IDX_CODE    = 6'h03;
  localparam logic [5:0]  IDX_ASPECT  = 6'h04;
  localparam logic [5:0]  IDX_FLAGS   = 6'h05;
  localparam logic [5:0]  IDX_BAR1    = 6'h06;
  localparam logic [5:0]  IDX_BAR2    = 6'h07;
  localparam logic [5:0]  IDX_PRESENT = 6'h08;
  localparam int unsigned PASS_BIT    = 0;
  localparam int unsigned CHANGE_BIT  = 1;

  // ----------------------------------------------------------------
  // state types and reset values
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FWD  = 4'b0010,
    ST_DROP = 4'b0100,
    ST_ANC  = 4'b1000
  } pkt_state_t;

  typedef struct packed {
    pkt_state_t          st;
    logic                pass;
    logic                chg;
    logic [3:0]          code;
    logic                aspect;
    logic [3:0]          flags;
    logic [15:0]         bar1;
    logic [15:0]         bar2;
    logic                seen;
    logic                present;
    logic                ov;
    logic [DATA_W-1:0]   od;
    logic                osop;
    logic                oeop;
    logic [31:0]         rdata;
    logic                slverr;
  } core_t;

  typedef struct packed {
    logic [7:0]  pos;
    logic [7:0]  dc;
    logic        match;
    logic [3:0]  code;
    logic        aspect;
    logic [3:0]  flags;
    logic [15:0] bar1;
    logic [15:0] bar2;
    logic        hit;
  } parse_t;

  localparam core_t  CORE_RST  = '{st: ST_IDLE, default: '0};
  localparam parse_t PARSE_RST = '{default: '0};

endpackage : afd_extract_pkg

// >>> hdl/anc_word_parser.sv
// walks the words of an ancillary data packet and decodes format packets
// assumes words arrive one per accepted beat, start pulses on packet header
`timescale 1ns/1ps
`default_nettype none
module anc_word_parser
  import afd_extract_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        word_valid,
  input  wire logic [7:0]  word,
  output logic             hit,
  output logic [3:0]       code,
  output logic             aspect,
  output logic [3:0]       flags,
  output logic [15:0]      bar1,
  output logic [15:0]      bar2
);

  parse_t q_ff;
  parse_t nxt_q;

  always_comb begin
    nxt_q     = q_ff;
    nxt_q.hit = 1'b0;
    if (start) begin
      nxt_q.pos = POS_DID;
    end else if (word_valid) begin
      nxt_q.pos = 8'(q_ff.pos + 8'h01);
      // both ids checked on every embedded packet
      if (q_ff.pos == POS_DID) nxt_q.match = (word == AFD_DID);
      if (q_ff.pos == POS_SDID) nxt_q.match = q_ff.match & (word == AFD_SDID);
      if (q_ff.pos == POS_DC) begin
        nxt_q.dc = word;
        if (word == 8'h00) nxt_q.pos = POS_DID;
      end
      if (q_ff.match) begin
        if (q_ff.pos == POS_CODE) begin
          nxt_q.code   = word[6:3];
          nxt_q.aspect = word[2];
        end
        if (q_ff.pos == POS_FLAGS) nxt_q.flags = word[7:4];
        // pixel or line bounds depending on the code
        if (q_ff.pos == POS_BAR1_HI) nxt_q.bar1[15:8] = word;
        if (q_ff.pos == POS_BAR1_LO) nxt_q.bar1[7:0] = word;
        if (q_ff.pos == POS_BAR2_HI) nxt_q.bar2[15:8] = word;
        if (q_ff.pos == POS_BAR2_LO) nxt_q.bar2[7:0] = word;
      end
      if (q_ff.pos > POS_DC && q_ff.pos == 8'(q_ff.dc + POS_LAST_OFS)) begin
        nxt_q.pos = POS_DID;
        // short or long payloads are not trusted as format data
        nxt_q.hit = q_ff.match & (q_ff.dc == AFD_DC);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= PARSE_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign hit    = q_ff.hit;
  assign code   = q_ff.code;
  assign aspect = q_ff.aspect;
  assign flags  = q_ff.flags;
  assign bar1   = q_ff.bar1;
  assign bar2   = q_ff.bar2;

endmodule : anc_word_parser
`default_nettype wire

// >>> hdl/active_format_extractor.sv
// packet filter and format register block behind an apb slave
// assumes the upstream stream carries the packet type in the low nibble of
// the start beat, and that apb runs on the same pclk
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module active_format_extractor
  import afd_extract_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [DATA_W-1:0] in_data,
  input  wire logic              in_sop,
  input  wire logic              in_eop,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [DATA_W-1:0]      out_data,
  output logic                   out_sop,
  output logic                   out_eop,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  core_t       q_ff;
  core_t       nxt_q;
  logic        acc;
  logic        fire;
  logic        start_anc;
  logic        hit;
  logic        changed;
  logic [3:0]  p_code;
  logic        p_aspect;
  logic [3:0]  p_flags;
  logic [15:0] p_bar1;
  logic [15:0] p_bar2;
  logic [5:0]  idx;
  logic        mapped;
  logic        wr_access;
  logic        setup;

  // ----------------------------------------------------------------
  // stream handshake
  // ----------------------------------------------------------------
  // discarded beats after the start beat never wait on the downstream side
  assign in_ready = (q_ff.st == ST_DROP || q_ff.st == ST_ANC) ? 1'b1
                  : (!q_ff.ov || out_ready);
  assign acc = in_valid && in_ready;
  assign start_anc = acc && in_sop && q_ff.st == ST_IDLE
                   && in_data[3:0] == TYPE_ANC;

  anc_word_parser u_parser (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (start_anc),
    .word_valid (acc && q_ff.st == ST_ANC),
    .word       (in_data[7:0]),
    .hit        (hit),
    .code       (p_code),
    .aspect     (p_aspect),
    .flags      (p_flags),
    .bar1       (p_bar1),
    .bar2       (p_bar2)
  );

  assign changed = hit && ({p_code, p_aspect, p_flags, p_bar1, p_bar2}
                        != {q_ff.code, q_ff.aspect, q_ff.flags, q_ff.bar1, q_ff.bar2});

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign idx       = paddr[ADDR_W-1:2];
  assign mapped    = (paddr[1:0] == 2'h0) && (idx <= IDX_PRESENT);
  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    fire  = 1'b0;
    if (q_ff.ov && out_ready) nxt_q.ov = 1'b0;

    // set ahead of the case so an image start in the same cycle consumes it
    if (hit) nxt_q.seen = 1'b1;

    // the pass bit is sampled per packet so no packet is cut short
    unique case (q_ff.st)
      ST_IDLE: begin
        if (acc && in_sop) begin
          if (in_data[3:0] == TYPE_ANC) begin
            nxt_q.st = in_eop ? ST_IDLE : ST_ANC;
          end else if (q_ff.pass) begin
            fire     = 1'b1;
            nxt_q.st = in_eop ? ST_IDLE : ST_FWD;
          end else begin
            nxt_q.st = in_eop ? ST_IDLE : ST_DROP;
          end
          if (in_data[3:0] == TYPE_IMG) begin
            nxt_q.present = q_ff.seen || hit;
            nxt_q.seen    = 1'b0;
          end
        end
      end
      ST_FWD: begin
        if (acc) begin
          fire = 1'b1;
          if (in_eop) nxt_q.st = ST_IDLE;
        end
      end
      ST_DROP, ST_ANC: begin
        if (acc && in_eop) nxt_q.st = ST_IDLE;
      end
    endcase

    if (fire) begin
      nxt_q.ov   = 1'b1;
      nxt_q.od   = in_data;
      nxt_q.osop = in_sop;
      nxt_q.oeop = in_eop;
    end

    // decoded registers move only on a matching packet
    if (hit) begin
      nxt_q.code   = p_code;
      nxt_q.aspect = p_aspect;
      nxt_q.flags  = p_flags;
      nxt_q.bar1   = p_bar1;
      nxt_q.bar2   = p_bar2;
    end

    if (wr_access) begin
      if (idx == IDX_CTRL && paddr[1:0] == 2'h0) nxt_q.pass = pwdata[PASS_BIT];
      if (idx == IDX_IRQ && paddr[1:0] == 2'h0 && pwdata[CHANGE_BIT]) begin
        nxt_q.chg = 1'b0;
      end
    end
    // set after clear so a same-cycle event survives
    if (changed) nxt_q.chg = 1'b1;

    // read data is latched in the setup cycle, so no wait states
    if (setup) begin
      nxt_q.slverr = !mapped;
      nxt_q.rdata  = 32'h0000_0000;
      if (mapped) begin
        unique case (idx)
          IDX_CTRL:    nxt_q.rdata[PASS_BIT] = q_ff.pass;
          IDX_IRQ:     nxt_q.rdata[CHANGE_BIT] = q_ff.chg;
          IDX_CODE:    nxt_q.rdata[3:0] = q_ff.code;
          IDX_ASPECT:  nxt_q.rdata[0] = q_ff.aspect;
          IDX_FLAGS:   nxt_q.rdata[3:0] = q_ff.flags;
          IDX_BAR1:    nxt_q.rdata[15:0] = q_ff.bar1;
          IDX_BAR2:    nxt_q.rdata[15:0] = q_ff.bar2;
          IDX_PRESENT: nxt_q.rdata[0] = q_ff.present;
          default:     nxt_q.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= CORE_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata    = q_ff.rdata;
  assign pready    = 1'b1;
  assign pslverr   = q_ff.slverr && psel && penable;
  assign out_valid = q_ff.ov;
  assign out_data  = q_ff.od;
  assign out_sop   = q_ff.osop;
  assign out_eop   = q_ff.oeop;
  assign irq       = q_ff.chg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_no_anc_out: assert property (
    out_valid && out_sop |-> out_data[3:0] != TYPE_ANC)
    else $error("ancillary packet reached output");

  a_anc_entry: assert property (
    start_anc && !in_eop |=> q_ff.st == ST_ANC)
    else $error("type 13 packet not taken as ancillary");

  a_format_load: assert property (
    hit |=> q_ff.code == $past(p_code) && q_ff.bar2 == $past(p_bar2))
    else $error("matching packet not loaded");

  a_drop_quiet: assert property (
    fire |-> q_ff.st == ST_FWD || (q_ff.st == ST_IDLE && q_ff.pass))
    else $error("beat forwarded while dropping");

  a_fwd_copy: assert property (
    q_ff.st == ST_FWD && acc |=> out_valid && out_data == $past(in_data)
      && out_eop == $past(in_eop))
    else $error("forwarded beat altered");

  a_change_set: assert property (
    changed |=> q_ff.chg ##1 (q_ff.chg || $past(wr_access)))
    else $error("change flag not raised");

  a_change_clear: assert property (
    wr_access && idx == IDX_IRQ && paddr[1:0] == 2'h0 && pwdata[CHANGE_BIT] && !changed
      |=> !q_ff.chg)
    else $error("change flag not cleared");

  a_irq_pin: assert property (
    $rose(q_ff.chg) |-> irq && $past(changed))
    else $error("irq without change event");

  a_ro_hold: assert property (
    !hit |=> $stable(q_ff.code) && $stable(q_ff.bar1) && $stable(q_ff.flags))
    else $error("decoded register moved without a match");

  a_present_flag: assert property (
    acc && in_sop && q_ff.st == ST_IDLE && in_data[3:0] == TYPE_IMG
      |=> q_ff.present == $past(q_ff.seen || hit) && !q_ff.seen)
    else $error("image presence flag wrong");

endmodule : active_format_extractor
`default_nettype wire

// >>> test/stream_source.sv
// upstream packet source driving the extractor input stream
// assumes one pclk domain; the bench queues beats with push
`timescale 1ns/1ps
`default_nettype none
module stream_source (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       in_ready,
  input  wire logic [3:0] gap,
  output logic            in_valid,
  output logic [9:0]      in_data,
  output logic            in_sop,
  output logic            in_eop
);
  logic [11:0] beats[$];
  int          wait_cnt;

  task automatic push(input logic [9:0] d, input logic s, input logic e);
    beats.push_back({s, e, d});
  endtask : push

  initial begin
    in_valid = 1'b0;
    in_data  = 10'h000;
    in_sop   = 1'b0;
    in_eop   = 1'b0;
    wait_cnt = 0;
  end

  // ----------------------------------------------------------------
  // beat issue: hold until taken, optional idle gap between beats
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_valid <= 1'b0;
    end else if (in_valid && !in_ready) begin
      in_valid <= 1'b1;
    end else if (wait_cnt != 0 || beats.size() == 0) begin
      in_valid <= 1'b0;
      in_sop   <= 1'b0;
      in_eop   <= 1'b0;
      // idle data flips so a stale beat can never look valid
      in_data  <= ~in_data;
      if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end else begin
      {in_sop, in_eop, in_data} <= beats.pop_front();
      in_valid <= 1'b1;
      wait_cnt <= int'(gap);
    end
  end
endmodule : stream_source
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the active format extractor
// assumes stream_source upstream and a toggling out_ready downstream
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  import afd_extract_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready, pslverr, in_valid, in_ready, in_sop, in_eop;
  logic [DATA_W-1:0] in_data, out_data;
  logic              out_valid, out_sop, out_eop, irq;
  logic              out_ready = 1'b1;
  logic [3:0]        gap = 4'h0;
  logic [11:0]       got[$];
  int                mismatches = 0;
  int                compares = 0;

  always #4 pclk = ~pclk;
  // downstream stalls every other cycle
  always @(posedge pclk) out_ready <= ~out_ready;
  always @(posedge pclk) if (out_valid && out_ready) got.push_back({out_sop, out_eop, out_data});

  active_format_extractor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .in_sop(in_sop), .in_eop(in_eop), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop), .irq(irq));
  stream_source src (.pclk(pclk), .presetn(presetn), .in_ready(in_ready), .gap(gap),
    .in_valid(in_valid), .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop));

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // apb master and stream helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin mismatches++; final_report(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, idx, wd, rd, er);
  endtask : wr

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] ex, input string nm);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, idx, 32'h0, rd, er);
    `CHK(nm, ex, rd)
  endtask : rd_chk

  task automatic settle();
    int n;
    n = 0;
    while ((src.beats.size() != 0 || in_valid) && n < 2000) begin @(posedge pclk); n++; end
    if (n >= 2000) begin mismatches++; final_report(); end
    repeat (6) @(posedge pclk);
  endtask : settle

  task automatic img(input int n);
    src.push(10'h000, 1'b1, 1'b0);
    for (int i = 1; i < n; i++) src.push(10'h3A5 - 10'(i), 1'b0, i == n - 1);
    settle();
  endtask : img

  // decoy embedded packet with a wrong secondary id ahead of the real one
  task automatic afd(input logic [3:0] c, input logic a, input logic [3:0] f,
                     input logic [15:0] b1, input logic [15:0] b2);
    logic [7:0] w[$];
    w = '{8'h41, 8'h06, 8'h08, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
          8'h41, 8'h05, 8'h08, {1'b0, c, a, 2'b00}, 8'h00, 8'h00, {f, 4'h0},
          b1[15:8], b1[7:0], b2[15:8], b2[7:0]};
    src.push(10'h00D, 1'b1, 1'b0);
    foreach (w[i]) src.push({2'b00, w[i]}, 1'b0, i == w.size() - 1);
    settle();
  endtask : afd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] rd;
    logic        er;
    for (int i = 0; i < 9; i++) rd_chk(6'(i), 32'h0, "reset word");
    apb(1'b0, 6'h09, 32'h0, rd, er);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
  endtask : t_reset

  task automatic t_drop();
    got.delete();
    img(3);
    `CHK("dropped beats", 0, got.size())
  endtask : t_drop

  task automatic t_pass();
    got.delete();
    wr(IDX_CTRL, 32'h1);
    rd_chk(IDX_CTRL, 32'h1, "ctrl");
    gap = 4'h2;
    img(3);
    gap = 4'h0;
    `CHK("pass count", 3, got.size())
    `CHK("beat0", 12'h800, got[0])
    `CHK("beat1", 12'h3A4, got[1])
    `CHK("beat2", 12'h7A3, got[2])
  endtask : t_pass

  task automatic t_afd();
    logic [3:0]  c[3]  = '{4'b0100, 4'b0011, 4'b1100};
    logic [15:0] b1[3] = '{16'h0000, 16'h00F0, 16'h0030};
    logic [15:0] b2[3] = '{16'h0000, 16'h0690, 16'h0408};
    got.delete();
    for (int i = 0; i < 3; i++) begin
      afd(c[i], i[0], 4'(i + 9), b1[i], b2[i]);
      `CHK("irq set", 1'b1, irq)
      rd_chk(IDX_IRQ, 32'h2, "irq reg");
      rd_chk(IDX_CODE, {28'h0, c[i]}, "code");
      rd_chk(IDX_ASPECT, {31'h0, i[0]}, "aspect");
      rd_chk(IDX_FLAGS, 32'(i + 9), "flags");
      rd_chk(IDX_BAR1, {16'h0, b1[i]}, "bar1");
      rd_chk(IDX_BAR2, {16'h0, b2[i]}, "bar2");
      wr(IDX_BAR1, 32'hFFFF);
      rd_chk(IDX_BAR1, {16'h0, b1[i]}, "bar1 hold");
      wr(IDX_IRQ, 32'h2);
      rd_chk(IDX_IRQ, 32'h0, "irq clr");
      `CHK("irq low", 1'b0, irq)
    end
    afd(c[2], 1'b0, 4'hB, b1[2], b2[2]);
    `CHK("no change irq", 1'b0, irq)
    `CHK("anc stripped", 0, got.size())
  endtask : t_afd

  task automatic t_present();
    img(2);
    rd_chk(IDX_PRESENT, 32'h1, "present");
    img(2);
    rd_chk(IDX_PRESENT, 32'h0, "absent");
  endtask : t_present

  // reset in mid-run with loaded registers: ctrl, code and bar2 read back rest values
  task automatic t_mid_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(IDX_CTRL, 32'h0, "ctrl after reset");
    rd_chk(IDX_CODE, 32'h0, "code after reset");
    rd_chk(IDX_BAR2, 32'h0, "bar2 after reset");
    got.delete();
    img(2);
    `CHK("drop after reset", 0, got.size())
  endtask : t_mid_reset

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_drop();
    t_pass();
    t_afd();
    t_present();
    t_mid_reset();
    final_report();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
